// ==== design/tce_pkg.sv ====
package tce_pkg;

  localparam logic [7:0] TCE_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TCE_OFF_CMP_LO = 8'h04;
  localparam logic [7:0] TCE_OFF_CMP_HI = 8'h08;
  localparam logic [7:0] TCE_OFF_STATUS = 8'h0C;
  localparam logic [7:0] TCE_OFF_MASK   = 8'h10;
  localparam logic [7:0] TCE_OFF_TIMER  = 8'h14;

  localparam int TCE_MODE_LSB = 0;
  localparam int TCE_DUTY_LSB = 4;
  localparam int TCE_OCFG_LSB = 6;

  localparam int TCE_EV_MATCH = 0;
  localparam int TCE_EV_TRIG  = 1;
  localparam int TCE_NUM_EV   = 2;

  localparam logic [7:0]  TCE_CTRL_RST   = 8'h00;
  localparam logic [7:0]  TCE_CMP_RST    = 8'h00;
  localparam logic [1:0]  TCE_EV_RST     = 2'h0;
  localparam logic [31:0] TCE_RDATA_RST  = 32'h0000_0000;

  typedef enum logic [3:0] {
    TCE_MODE_OFF    = 4'b0000,
    TCE_MODE_TOGGLE = 4'b0010,
    TCE_MODE_SET    = 4'b1000,
    TCE_MODE_CLEAR  = 4'b1001,
    TCE_MODE_SWINT  = 4'b1010,
    TCE_MODE_TRIG   = 4'b1011
  } tce_mode_t;

  typedef struct packed {
    logic [1:0] out_cfg;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } tce_ctrl_t;

  typedef struct packed {
    logic [7:0] compare_high_byte;
    logic [7:0] compare_low_byte;
  } tce_cmp_t;

endpackage

// ==== design/tce_unit.sv ====
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module tce_unit
  import tce_pkg::*;
#(
  parameter bit ENHANCED = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] timer_count,
  input  wire logic        timer_tick,
  input  wire logic        timer_async_mode,
  input  wire logic        adc_enable,
  input  wire logic        sleep_mode,
  output logic             trigger_event,
  output logic             timer_clear,
  output logic             adc_start,
  output logic             unit_output_pin,
  output logic             unit_output_pin_oe,
  output logic             irq
);

  typedef enum logic [0:0] {
    TCE_RST_IDLE  = 1'b0,
    TCE_RST_ARMED = 1'b1
  } tce_rst_state_t;

  tce_ctrl_t      ctrl_q;
  tce_cmp_t       cmp_q;
  logic [1:0]     status_q;
  logic [1:0]     mask_q;
  logic [1:0]     ev_set;
  logic [1:0]     ev_clr;
  logic           eq;
  logic           eq_q;
  logic           match_evt;
  logic           latch_q;
  tce_rst_state_t rst_q;
  logic           access;
  logic           wr;
  logic           mapped;
  logic [31:0]    rdata;

  // Pin is driven only in the three output modes
  function automatic logic drives_pin(input logic [3:0] m);
    return (m == TCE_MODE_TOGGLE) || (m == TCE_MODE_SET) || (m == TCE_MODE_CLEAR);
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // APB: one wait state, so every answer comes from a flip-flop
  assign access = psel && penable && !pready;
  assign wr     = access && pwrite;
  assign mapped = is_reg(paddr, TCE_OFF_CTRL) || is_reg(paddr, TCE_OFF_CMP_LO)
               || is_reg(paddr, TCE_OFF_CMP_HI) || is_reg(paddr, TCE_OFF_STATUS)
               || is_reg(paddr, TCE_OFF_MASK) || is_reg(paddr, TCE_OFF_TIMER);

  always_comb begin
    rdata = TCE_RDATA_RST;
    unique case (paddr)
      TCE_OFF_CTRL:   rdata[7:0] = ctrl_q;
      TCE_OFF_CMP_LO: rdata[7:0] = cmp_q.compare_low_byte;
      TCE_OFF_CMP_HI: rdata[7:0] = cmp_q.compare_high_byte;
      TCE_OFF_STATUS: rdata[1:0] = status_q;
      TCE_OFF_MASK:   rdata[1:0] = mask_q;
      TCE_OFF_TIMER:  rdata[15:0] = timer_count;
      default:        rdata = TCE_RDATA_RST;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= TCE_RDATA_RST;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      prdata  <= (access && !pwrite) ? rdata : TCE_RDATA_RST;
    end
  end

  // Control register; output config bits exist on enhanced units only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= TCE_CTRL_RST;
    end else if (wr && is_reg(paddr, TCE_OFF_CTRL) && pstrb[0]) begin
      ctrl_q.unit_mode_select <= pwdata[TCE_MODE_LSB +: 4];
      ctrl_q.duty_low_bits    <= pwdata[TCE_DUTY_LSB +: 2];
      ctrl_q.out_cfg          <= ENHANCED ? pwdata[TCE_OCFG_LSB +: 2] : 2'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmp_q <= {TCE_CMP_RST, TCE_CMP_RST};
    end else begin
      if (wr && is_reg(paddr, TCE_OFF_CMP_LO) && pstrb[0]) begin
        cmp_q.compare_low_byte <= pwdata[7:0];
      end
      if (wr && is_reg(paddr, TCE_OFF_CMP_HI) && pstrb[0]) begin
        cmp_q.compare_high_byte <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= TCE_EV_RST;
    end else if (wr && is_reg(paddr, TCE_OFF_MASK) && pstrb[0]) begin
      mask_q <= pwdata[1:0];
    end
  end

  // Match detection on the system clock; no match while asleep, async timer gives no guarantee
  assign eq        = (cmp_q == timer_count);
  assign match_evt = eq && !eq_q && !sleep_mode
                  && (ctrl_q.unit_mode_select != TCE_MODE_OFF);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eq_q <= 1'b0;
    end else begin
      eq_q <= eq;
    end
  end

  assign ev_set[TCE_EV_MATCH] = match_evt;
  assign ev_set[TCE_EV_TRIG]  = match_evt && ctrl_q.unit_mode_select == TCE_MODE_TRIG;
  assign ev_clr = (wr && is_reg(paddr, TCE_OFF_STATUS) && pstrb[0]) ? pwdata[1:0] : 2'h0;

  // Sticky flags; a new event beats a same-cycle clear
  generate
    for (genvar i = 0; i < TCE_NUM_EV; i++) begin : g_ev
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          status_q[i] <= 1'b0;
        end else if (ev_set[i]) begin
          status_q[i] <= 1'b1;
        end else if (ev_clr[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // Compare output latch: same edge as the flag, forced low when control is zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_q <= 1'b0;
    end else if (ctrl_q == TCE_CTRL_RST) begin
      latch_q <= 1'b0;
    end else if (match_evt) begin
      unique case (ctrl_q.unit_mode_select)
        TCE_MODE_TOGGLE: latch_q <= !latch_q;
        TCE_MODE_SET:    latch_q <= 1'b1;
        TCE_MODE_CLEAR:  latch_q <= 1'b0;
        default:         latch_q <= latch_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unit_output_pin    <= 1'b0;
      unit_output_pin_oe <= 1'b0;
    end else begin
      unit_output_pin    <= latch_q;
      unit_output_pin_oe <= drives_pin(ctrl_q.unit_mode_select);
    end
  end

  // Trigger output follows the match edge directly, not the timer clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trigger_event <= 1'b0;
      adc_start     <= 1'b0;
    end else begin
      trigger_event <= ev_set[TCE_EV_TRIG];
      adc_start     <= ev_set[TCE_EV_TRIG] && adc_enable;
    end
  end

  // Timer reset waits for the timer's next tick and is dropped if the match goes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q       <= TCE_RST_IDLE;
      timer_clear <= 1'b0;
    end else begin
      timer_clear <= 1'b0;
      unique case (rst_q)
        TCE_RST_IDLE: begin
          if (ev_set[TCE_EV_TRIG] && !timer_async_mode) begin
            rst_q <= TCE_RST_ARMED;
          end
        end
        TCE_RST_ARMED: begin
          if (!eq || ctrl_q.unit_mode_select != TCE_MODE_TRIG) begin
            rst_q <= TCE_RST_IDLE;
          end else if (timer_tick) begin
            timer_clear <= 1'b1;
            rst_q       <= TCE_RST_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ==== bench/tce_unit_properties.sv ====
`timescale 1ns/1ns
module tce_unit_properties (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_tick,
  input wire logic        adc_enable,
  input wire logic        sleep_mode,
  input wire logic        trigger_event,
  input wire logic        timer_clear,
  input wire logic        adc_start,
  input wire logic        unit_output_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data leaks");
  trig_once_a: assert property (trigger_event |=> !trigger_event) else $error("trigger held");
  adc_trig_a: assert property (adc_start |-> trigger_event) else $error("stray start");
  trig_pin_a: assert property (trigger_event |-> !unit_output_pin_oe) else $error("pin taken");
  clear_tick_a: assert property (timer_clear |-> $past(timer_tick)) else $error("early clear");
  sleep_quiet_a: assert property (sleep_mode |=> !trigger_event) else $error("asleep");
  cover property (trigger_event && adc_start);
  cover property (timer_clear);
  cover property (pslverr);
endmodule

bind tce_unit tce_unit_properties u_tce_unit_properties (.clk, .nrst, .psel, .penable, .prdata,
  .pready, .pslverr, .timer_tick, .adc_enable, .sleep_mode, .trigger_event, .timer_clear,
  .adc_start, .unit_output_pin_oe);

// ==== bench/tce_timer_model.sv ====
`timescale 1ns/1ns
module tce_timer_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        run,
  input  wire logic        timer_clear,
  output logic      [15:0] timer_count,
  output logic             timer_tick
);
  logic [1:0] div_q;
  // Tick every fourth cycle, stopped while not running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 2'h0;
      timer_tick <= 1'b0;
    end else begin
      div_q <= run ? div_q + 2'h1 : div_q;
      timer_tick <= run && (div_q == 2'h2);
    end
  end
  // Synchronous timer; a clear raises no overflow
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_count <= 16'h0000;
    end else if (timer_clear) begin
      timer_count <= 16'h0000;
    end else if (timer_tick) begin
      timer_count <= timer_count + 16'h0001;
    end
  end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import tce_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        adc_enable = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        run = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, trigger_event, timer_clear, adc_start, timer_tick;
  logic        unit_output_pin, unit_output_pin_oe, irq;
  logic [15:0] timer_count;
  logic [32:0] exp_q[$];
  logic [7:0]  v;
  logic [3:0]  md[4] = '{TCE_MODE_SET, TCE_MODE_CLEAR, TCE_MODE_TOGGLE, TCE_MODE_SWINT};
  int          seed = 844;
  int          mismatches = 0;
  int          total_checks = 0;
  int          clears = 0;
  int          cycles = 0;
  always #4 clk = ~clk;
  tce_unit u_tce_unit (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .timer_count, .timer_tick, .timer_async_mode(1'b0),
    .adc_enable, .sleep_mode, .trigger_event, .timer_clear, .adc_start, .unit_output_pin,
    .unit_output_pin_oe, .irq);
  tce_timer_model u_tce_timer_model (.clk, .nrst, .run, .timer_clear, .timer_count, .timer_tick);
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected read result is queued at setup and compared when ready comes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
    if (timer_clear === 1'b1) clears++;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    v = 8'($random(seed));
    apb(0, TCE_OFF_CTRL, 0, 33'h0);
    apb(0, TCE_OFF_STATUS, 0, 33'h0);
    apb(0, 8'h18, 0, 33'h1_0000_0000);
    apb(1, TCE_OFF_CTRL, 32'hFFFF_FFF2, 0);
    apb(0, TCE_OFF_CTRL, 0, 33'hF2);
    apb(1, TCE_OFF_CMP_HI, {24'h0, v}, 0);
    apb(0, TCE_OFF_CMP_HI, 0, {25'h0, v});
    apb(1, TCE_OFF_CMP_HI, 0, 0);
    apb(1, TCE_OFF_MASK, 3, 0);
    for (int i = 0; i < 4; i++) begin
      apb(1, TCE_OFF_CMP_LO, 1, 0);
      apb(1, TCE_OFF_CTRL, {28'h0, md[i]}, 0);
      apb(1, TCE_OFF_CMP_LO, 0, 0);
      repeat (3) @(posedge clk);
      chk(unit_output_pin_oe, i != 3);
      if (i != 3) chk(unit_output_pin, i != 1);
      chk(irq, 1);
      apb(0, TCE_OFF_STATUS, 0, 33'h1);
      apb(1, TCE_OFF_STATUS, 1, 0);
    end
    sleep_mode <= 1'b1;
    apb(1, TCE_OFF_CMP_LO, 1, 0);
    apb(1, TCE_OFF_CMP_LO, 0, 0);
    repeat (2) @(posedge clk);
    sleep_mode <= 1'b0;
    apb(0, TCE_OFF_STATUS, 0, 33'h0);
    apb(1, TCE_OFF_CTRL, 0, 0);
    repeat (3) @(posedge clk);
    chk(unit_output_pin, 0);
    adc_enable <= v[0];
    apb(1, TCE_OFF_CMP_LO, 1, 0);
    apb(1, TCE_OFF_CTRL, {28'h0, TCE_MODE_TRIG}, 0);
    apb(1, TCE_OFF_CMP_LO, 0, 0);
    @(posedge clk iff trigger_event);
    chk(adc_start, adc_enable);
    // Timer held still, so the pending clear can only be cancelled
    apb(1, TCE_OFF_CMP_LO, 32'h80, 0);
    run <= 1'b1;
    repeat (40) @(posedge clk);
    v = 8'h40 + 8'($random(seed) & 63);
    adc_enable <= 1'b1;
    apb(1, TCE_OFF_CMP_LO, {24'h0, v}, 0);
    @(posedge clk iff trigger_event);
    chk(timer_count, v);
    chk(adc_start, 1);
    @(posedge clk iff timer_clear);
    run <= 1'b0;
    repeat (3) @(posedge clk);
    chk(clears, 1);
    apb(0, TCE_OFF_TIMER, 0, {17'h0, timer_count});
    apb(0, TCE_OFF_STATUS, 0, 33'h3);
    for (int i = 0; i < 3; i++) begin
      apb(1, i == 2 ? TCE_OFF_STATUS : TCE_OFF_MASK, i == 0 ? 0 : 3, 0);
      repeat (2) @(posedge clk);
      chk(irq, i == 1);
    end
    complete_run;
  end
endmodule
